// >>> hdl/sacp_consts.vh
// Constants for the serial conversion port
`ifndef SACP_CONSTS_VH
`define SACP_CONSTS_VH
`define SACP_CTRL_CLKS    5'h08
`define SACP_ACQ_CLK      5'h05
`define SACP_MUX_CLK      5'h06
`define SACP_FRAME_CLKS   5'h18
`define SACP_CONV_FIRST   5'h09
`define SACP_CONV_LAST    5'h14
`define SACP_BITS_12      4'hc
`define SACP_BITS_8       4'h8
`define SACP_RES_W        12
`define SACP_TRIAL_INIT   12'h800
`define SACP_CTRL_START   7
`define SACP_CTRL_CH_HI   6
`define SACP_CTRL_CH_LO   4
`define SACP_CTRL_MODE    3
`define SACP_CTRL_INMODE  2
`define SACP_CTRL_PD_HI   1
`define SACP_CTRL_PD_LO   0
`define SACP_CH_CODE_0    3'h1
`define SACP_CH_CODE_1    3'h5
`define SACP_CH_CODE_2    3'h2
`define SACP_CH_CODE_3    3'h6
`define SACP_SEL_COMMON   5'h10
`define SACP_BUF_W        13
`endif

// >>> hdl/sacp_buf2.v
// Two-entry result buffer with valid and ready on both sides
`timescale 1ns/1ns
module sacp_buf2 #(
	parameter W = 13
)(
	input  wire         ref_clk,       // System clock
	input  wire         sys_rst,       // Synchronous reset, active high
	input  wire         in_valid,      // Word offered
	input  wire [W-1:0] in_data,       // Word to store
	output reg          in_ready_reg,  // Room for one word
	output reg          out_valid_reg, // Head word valid
	output wire [W-1:0] out_data,      // Head word
	input  wire         out_ready      // Drain accepts head
);
	reg [W-1:0] ent_reg [0:1];
	reg [1:0]   cnt_reg;
	reg [1:0]   cnt_next;
	wire        push;
	wire        pop;

	////////////////////////////////////////////////////////////////
	// Handshakes
	assign push     = in_valid & in_ready_reg;
	assign pop      = out_valid_reg & out_ready;
	assign out_data = ent_reg[0];

	// Occupancy after this cycle
	always @*
	begin
		cnt_next = cnt_reg;
		if (push & ~pop)
			cnt_next = cnt_reg + 2'h1;
		else if (pop & ~push)
			cnt_next = cnt_reg - 2'h1;
	end

	////////////////////////////////////////////////////////////////
	// Storage, head entry is the output register
	always @(posedge ref_clk)
	begin
		if (sys_rst)
		begin
			ent_reg[0]    <= {W{1'b0}};
			ent_reg[1]    <= {W{1'b0}};
			cnt_reg       <= 2'h0;
			in_ready_reg  <= 1'b1;
			out_valid_reg <= 1'b0;
		end
		else
		begin
			if (pop)
				ent_reg[0] <= (cnt_reg == 2'h2) ? ent_reg[1] : in_data;
			else if (push && cnt_reg == 2'h0)
				ent_reg[0] <= in_data;
			if (push && (cnt_reg == 2'h2 || (cnt_reg == 2'h1 && ~pop)))
				ent_reg[1] <= in_data;
			cnt_reg       <= cnt_next;
			in_ready_reg  <= (cnt_next != 2'h2);
			out_valid_reg <= (cnt_next != 2'h0);
		end
	end
endmodule // sacp_buf2

// >>> hdl/sacp_port.v
// Serial control and conversion sequencer of a four-input converter
`timescale 1ns/1ns
`include "sacp_consts.vh"
module sacp_port (
	input  wire                    ref_clk,                 // System clock, 50 MHz
	input  wire                    sys_rst,                 // Synchronous reset, active high
	input  wire                    serial_clock_line,       // Host serial clock
	input  wire                    chip_select_n,           // Chip select, active low
	input  wire                    serial_data_in,          // Host serial data
	input  wire                    resolution_pin,          // High lets control bit pick 8 bits
	input  wire                    sar_compare_in,          // High when input is above trial level
	output reg                     serial_data_out_reg,     // Serial result bit
	output reg                     serial_data_oe_reg,      // Drives serial output when high
	output reg                     busy_out_reg,            // Conversion in progress
	output reg                     busy_oe_reg,             // Drives busy pin when high
	output reg                     sample_active_reg,       // Sample switch closed
	output reg  [3:0]              pos_input_sel_reg,       // Positive input, one-hot inputs 0..3
	output reg  [4:0]              neg_input_sel_reg,       // Negative input, bit 4 is common
	output reg  [`SACP_RES_W-1:0]  sar_trial_code_reg,      // Trial code for the capacitor array
	output reg  [1:0]              power_mode_reg,          // Power-down bits of last word
	output wire                    result_valid,            // Buffered result ready
	output wire [`SACP_BUF_W-1:0]  result_data,             // {eight_bit, code}
	input  wire                    result_ready             // Receiver takes result
);
	reg                    sclk_prev_reg;
	reg                    active_reg;
	reg  [4:0]             clk_cnt_reg;
	reg  [6:0]             ctrl_sh_reg;
	reg                    eight_bit_reg;
	reg  [`SACP_RES_W-1:0] mask_reg;
	reg                    converting_reg;
	reg                    push_reg;
	reg  [`SACP_RES_W-1:0] push_code_reg;
	reg  [3:0]             step_cnt_reg;
	wire                   buf_in_ready;
	wire                   rise;
	wire                   fall;
	wire [7:0]             ctrl_byte;
	wire [3:0]             nbits;
	wire [`SACP_RES_W-1:0] trial_kept;
	reg  [3:0]             pos_next;
	reg  [4:0]             neg_next;

	////////////////////////////////////////////////////////////////
	// Serial clock edges, inputs already synchronous
	assign rise       = serial_clock_line & ~sclk_prev_reg & ~chip_select_n;
	assign fall       = ~serial_clock_line & sclk_prev_reg & ~chip_select_n;
	assign ctrl_byte  = {ctrl_sh_reg, serial_data_in};
	assign nbits      = eight_bit_reg ? `SACP_BITS_8 : `SACP_BITS_12;
	assign trial_kept = sar_compare_in ? sar_trial_code_reg : (sar_trial_code_reg & ~mask_reg);

	// Mux decode from channel code and mode bit seen at the sixth clock
	always @*
	begin
		pos_next = 4'h0;
		neg_next = 5'h00;
		case (ctrl_sh_reg[3:1])
			`SACP_CH_CODE_0:
			begin
				pos_next = 4'h1;
				neg_next = serial_data_in ? `SACP_SEL_COMMON : 5'h02;
			end
			`SACP_CH_CODE_1:
			begin
				pos_next = 4'h2;
				neg_next = serial_data_in ? `SACP_SEL_COMMON : 5'h01;
			end
			`SACP_CH_CODE_2:
			begin
				pos_next = 4'h4;
				neg_next = serial_data_in ? `SACP_SEL_COMMON : 5'h08;
			end
			`SACP_CH_CODE_3:
			begin
				pos_next = 4'h8;
				neg_next = serial_data_in ? `SACP_SEL_COMMON : 5'h04;
			end
			default:
			begin
				pos_next = 4'h0;
				neg_next = 5'h00;
			end
		endcase
	end

	////////////////////////////////////////////////////////////////
	// Frame sequencer
	always @(posedge ref_clk)
	begin
		if (sys_rst)
		begin
			sclk_prev_reg       <= 1'b0;
			active_reg          <= 1'b0;
			clk_cnt_reg         <= 5'h00;
			ctrl_sh_reg         <= 7'h00;
			eight_bit_reg       <= 1'b0;
			mask_reg            <= {`SACP_RES_W{1'b0}};
			converting_reg      <= 1'b0;
			push_reg            <= 1'b0;
			push_code_reg       <= {`SACP_RES_W{1'b0}};
			step_cnt_reg        <= 4'h0;
			serial_data_out_reg <= 1'b0;
			serial_data_oe_reg  <= 1'b0;
			busy_out_reg        <= 1'b0;
			busy_oe_reg         <= 1'b0;
			sample_active_reg   <= 1'b0;
			pos_input_sel_reg   <= 4'h0;
			neg_input_sel_reg   <= 5'h00;
			sar_trial_code_reg  <= {`SACP_RES_W{1'b0}};
			power_mode_reg      <= 2'h3;
		end
		else
		begin
			sclk_prev_reg      <= serial_clock_line;
			push_reg           <= 1'b0;
			serial_data_oe_reg <= ~chip_select_n;
			busy_oe_reg        <= ~chip_select_n;
			if (chip_select_n)
			begin
				// Deselect ends any frame
				active_reg          <= 1'b0;
				converting_reg      <= 1'b0;
				clk_cnt_reg         <= 5'h00;
				serial_data_out_reg <= 1'b0;
				busy_out_reg        <= 1'b0;
				sample_active_reg   <= 1'b0;
			end
			else if (rise)
			begin
				if (~active_reg)
				begin
					// Wait for high start bit, only with buffer room
					if (serial_data_in & buf_in_ready)
					begin
						active_reg  <= 1'b1;
						clk_cnt_reg <= 5'h01;
						ctrl_sh_reg <= 7'h01;
					end
				end
				else
				begin
					if (clk_cnt_reg != `SACP_FRAME_CLKS)
						clk_cnt_reg <= clk_cnt_reg + 5'h01;
					if (clk_cnt_reg < `SACP_CTRL_CLKS - 5'h01)
						ctrl_sh_reg <= ctrl_byte[6:0];
					if (clk_cnt_reg == `SACP_ACQ_CLK - 5'h01)
						sample_active_reg <= 1'b1;
					if (clk_cnt_reg == `SACP_MUX_CLK - 5'h01)
					begin
						pos_input_sel_reg <= pos_next;
						neg_input_sel_reg <= neg_next;
					end
					if (clk_cnt_reg == `SACP_CTRL_CLKS - 5'h01)
					begin
						// Control word complete: hold and start conversion
						sample_active_reg  <= 1'b0;
						converting_reg     <= 1'b1;
						busy_out_reg       <= 1'b1;
						eight_bit_reg      <= resolution_pin & ctrl_byte[`SACP_CTRL_MODE];
						power_mode_reg     <= ctrl_byte[`SACP_CTRL_PD_HI:`SACP_CTRL_PD_LO];
						sar_trial_code_reg <= `SACP_TRIAL_INIT;
						mask_reg           <= `SACP_TRIAL_INIT;
						step_cnt_reg       <= 4'h0;
					end
				end
			end
			else if (fall && active_reg)
			begin
				if (converting_reg && clk_cnt_reg >= `SACP_CONV_FIRST && clk_cnt_reg <= `SACP_CONV_LAST)
				begin
					// One decision per clock, shifted out MSB first
					serial_data_out_reg <= sar_compare_in;
					sar_trial_code_reg  <= trial_kept | (mask_reg >> 1);
					mask_reg            <= mask_reg >> 1;
					step_cnt_reg        <= step_cnt_reg + 4'h1;
					if (step_cnt_reg + 4'h1 == nbits)
					begin
						converting_reg <= 1'b0;
						busy_out_reg   <= 1'b0;
						push_reg       <= 1'b1;
						push_code_reg  <= trial_kept;
					end
				end
				else
					serial_data_out_reg <= 1'b0;
				if (clk_cnt_reg == `SACP_FRAME_CLKS)
				begin
					active_reg  <= 1'b0;
					clk_cnt_reg <= 5'h00;
				end
			end
		end
	end

	////////////////////////////////////////////////////////////////
	// Result buffer toward the receiver
	sacp_buf2 #(
		.W (`SACP_BUF_W)
	) u_buf (
		.ref_clk       (ref_clk),
		.sys_rst       (sys_rst),
		.in_valid      (push_reg),
		.in_data       ({eight_bit_reg, push_code_reg}),
		.in_ready_reg  (buf_in_ready),
		.out_valid_reg (result_valid),
		.out_data      (result_data),
		.out_ready     (result_ready)
	);
endmodule // sacp_port

// >>> bench/sacp_port_monitor.sv
// Protocol checker for the serial conversion port
`timescale 1ns/1ns
`include "sacp_consts.vh"
module sacp_port_monitor (
	input wire                    ref_clk,             // Clock
	input wire                    sys_rst,             // Reset
	input wire                    chip_select_n,       // Select
	input wire                    serial_data_oe_reg,  // Out enable
	input wire                    busy_out_reg,        // Busy
	input wire                    busy_oe_reg,         // Busy enable
	input wire                    sample_active_reg,   // Sampling
	input wire [3:0]              pos_input_sel_reg,   // Positive mux
	input wire [4:0]              neg_input_sel_reg,   // Negative mux
	input wire [`SACP_RES_W-1:0]  sar_trial_code_reg,  // Trial code
	input wire                    result_valid,        // Result valid
	input wire [`SACP_BUF_W-1:0]  result_data,         // Result word
	input wire                    result_ready         // Result taken
);
	default clocking @(posedge ref_clk); endclocking
	default disable iff (sys_rst);
	////////////////////////////////////////////////////////////
	// Output enables follow select one clock late
	property p_oe;
		!$past(sys_rst) |-> serial_data_oe_reg == !$past(chip_select_n);
	endproperty
	a_oe: assert property (p_oe) else $error("output enable wrong");
	property p_busy_oe;
		busy_oe_reg == serial_data_oe_reg;
	endproperty
	a_busy_oe: assert property (p_busy_oe) else $error("busy enable wrong");
	// Conversion starts from mid scale, sampling ends into hold
	property p_trial;
		$rose(busy_out_reg) |-> sar_trial_code_reg == 12'h800;
	endproperty
	a_trial: assert property (p_trial) else $error("trial start wrong");
	property p_hold;
		$fell(sample_active_reg) && !chip_select_n && !$past(chip_select_n) |-> busy_out_reg;
	endproperty
	a_hold: assert property (p_hold) else $error("hold without busy");
	property p_acq;
		$rose(sample_active_reg) |-> (sample_active_reg || chip_select_n) [*8];
	endproperty
	a_acq: assert property (p_acq) else $error("sampling too short");
	// Mux picks at most one input per side, never the same
	property p_mux;
		$onehot0(pos_input_sel_reg) && $onehot0(neg_input_sel_reg) && (pos_input_sel_reg & neg_input_sel_reg[3:0]) == 4'h0;
	endproperty
	a_mux: assert property (p_mux) else $error("mux select wrong");
	// Held result stays put, short results pad low bits
	property p_stall;
		result_valid && !result_ready |=> result_valid && $stable(result_data);
	endproperty
	a_stall: assert property (p_stall) else $error("result lost");
	property p_eight;
		result_valid && result_data[12] |-> result_data[3:0] == 4'h0;
	endproperty
	a_eight: assert property (p_eight) else $error("short result padded wrong");
endmodule // sacp_port_monitor
bind sacp_port sacp_port_monitor i_mon (.ref_clk(ref_clk), .sys_rst(sys_rst), .chip_select_n(chip_select_n),
	.serial_data_oe_reg(serial_data_oe_reg), .busy_out_reg(busy_out_reg), .busy_oe_reg(busy_oe_reg),
	.sample_active_reg(sample_active_reg), .pos_input_sel_reg(pos_input_sel_reg),
	.neg_input_sel_reg(neg_input_sel_reg), .sar_trial_code_reg(sar_trial_code_reg),
	.result_valid(result_valid), .result_data(result_data), .result_ready(result_ready));

// >>> bench/sacp_host.sv
// Host serial port model sending framed control bytes
`timescale 1ns/1ns
module sacp_host (
	input  wire        ref_clk,  // Clock
	input  wire        sdo,      // Device output
	output reg         sclk,     // Serial clock, idle low
	output reg         cs_n,     // Select
	output reg         din,      // Control data
	output reg  [23:0] rx        // Bits seen at rising edges
);
	initial
	begin
		{sclk, cs_n, din, rx} = {3'h3, 24'h0};
	end
	////////////////////////////////////////////////////////////
	// One frame, cut after stop_at clocks for an abort
	task frame(input [7:0] c, input integer stop_at);
		integer k;
		begin
			@(negedge ref_clk);
			cs_n = 1'b0;
			for (k = 0; k < stop_at; k = k + 1)
			begin
				din = (k < 8) ? c[7 - k] : 1'b0;
				repeat (3) @(negedge ref_clk);
				sclk = 1'b1;
				rx = {rx[22:0], sdo};
				repeat (3) @(negedge ref_clk);
				sclk = 1'b0;
			end
			repeat (3) @(negedge ref_clk);
			cs_n = 1'b1;
			din = 1'b1;
		end
	endtask
endmodule // sacp_host

// >>> bench/testbench.sv
// Self-checking bench for the serial conversion port
`timescale 1ns/1ns
module testbench;
	reg         ref_clk, sys_rst, res_pin, rdy, rnd;
	reg  [11:0] tgt;
	reg  [12:0] q[$];
	wire        sclk, cs_n, din, dout, oe, rv;
	wire [3:0]  pos;
	wire [4:0]  neg;
	wire [11:0] trial;
	wire [1:0]  pm;
	wire [12:0] rd;
	wire [23:0] rx;
	integer     n_errors, checks, i, n;
	integer     cyc = 0;
	sacp_port i_dut (.ref_clk(ref_clk), .sys_rst(sys_rst), .serial_clock_line(sclk), .chip_select_n(cs_n),
		.serial_data_in(din), .resolution_pin(res_pin), .sar_compare_in(tgt >= trial),
		.serial_data_out_reg(dout), .serial_data_oe_reg(oe), .busy_out_reg(), .busy_oe_reg(),
		.sample_active_reg(), .pos_input_sel_reg(pos), .neg_input_sel_reg(neg), .sar_trial_code_reg(trial),
		.power_mode_reg(pm), .result_valid(rv), .result_data(rd), .result_ready(rdy));
	sacp_host i_host (.ref_clk(ref_clk), .sdo(oe ? dout : 1'b1), .sclk(sclk), .cs_n(cs_n), .din(din), .rx(rx));
	initial
	begin
		ref_clk = 1'b0;
		forever #10 ref_clk = ~ref_clk;
	end
	////////////////////////////////////////////////////////////
	// Timeout, random drain and result compare
	always @(negedge ref_clk)
		if (rnd) rdy <= $urandom;
	always @(posedge ref_clk)
	begin
		cyc = cyc + 1;
		if (cyc == 20000)
		begin
			n_errors = n_errors + 1;
			end_of_test;
		end
		if (!sys_rst && rv && rdy)
		begin
			chk(q.size() > 0 && rd === q[0]);
			if (q.size() > 0) void'(q.pop_front());
		end
	end
	task chk(input ok);
		begin
			checks = checks + 1;
			if (!ok)
			begin
				n_errors = n_errors + 1;
				$display("ERROR %0t mismatch", $time);
			end
		end
	endtask
	// Expected mux selects, {negative, positive}; unused codes pick nothing
	function [8:0] mux(input [7:0] c);
		reg [3:0] p;
		begin
			case (c[6:4])
				3'h1: p = 4'h1;
				3'h5: p = 4'h2;
				3'h2: p = 4'h4;
				3'h6: p = 4'h8;
				default: p = 4'h0;
			endcase
			mux = {(p == 4'h0) ? 5'h00 : c[2] ? 5'h10 : {1'b0, p[2], p[3], p[0], p[1]}, p};
		end
	endfunction
	// One frame with its expected serial bits and result word
	task run(input [7:0] c, input [11:0] t, input ok);
		reg [12:0] w;
		begin
			tgt = t;
			w = (res_pin & c[3]) ? {1'b1, t[11:4], 4'h0} : {1'b0, t};
			if (ok) q.push_back(w);
			i_host.frame(c, 24);
			chk(rx === (ok ? {9'h0, w[11:0], 3'h0} : 24'h0));
			if (ok) chk({neg, pos, pm} === {mux(c), c[1:0]});
			$display("frame %h done", c);
		end
	endtask
	task end_of_test;
		begin
			$display("checks %0d errors %0d", checks, n_errors);
			if (n_errors == 0 && checks > 0)
				$display("All checks passed");
			else
				$display("Checks failed");
			$finish;
		end
	endtask
	// Main sequence
	initial
	begin
		{sys_rst, res_pin, rdy, rnd, tgt, n_errors, checks} = {4'ha, 12'h0, 32'h0, 32'h0};
		n = $urandom(32'h2c75);
		repeat (2) @(negedge ref_clk);
		sys_rst = 1'b0;
		rnd = 1'b1;
		// All four channel codes in both modes, random width pin and power bits
		for (i = 0; i < 8; i = i + 1)
		begin
			n = $urandom;
			res_pin = n[4];
			run({1'b1, i[0], i[1], ~i[1], n[3], i[2], n[1:0]}, $urandom, 1'b1);
		end
		res_pin = 1'b1;
		run(8'h9f, 12'hfff, 1'b1);
		run(8'hd4, 12'h001, 1'b1);
		run(8'hbf, $urandom, 1'b1);
		res_pin = 1'b0;
		run(8'hab, 12'h7ff, 1'b1);
		run(8'h00, 12'h0, 1'b0);
		i_host.frame(8'h8f, 12);
		run(8'he7, $urandom, 1'b1);
		// Stalled receiver fills the buffer, third start refused
		rnd = 1'b0;
		@(negedge ref_clk);
		rdy = 1'b1;
		repeat (3) @(negedge ref_clk);
		rdy = 1'b0;
		run(8'h97, $urandom, 1'b1);
		run(8'ha3, $urandom, 1'b1);
		run(8'hd7, $urandom, 1'b0);
		rdy = 1'b1;
		repeat (10) @(negedge ref_clk);
		chk(q.size() == 0);
		end_of_test;
	end
endmodule // testbench
